// ===== rtl/otls_pkg.sv
// constants shared by the overtravel limit stop control block
package otls_pkg;

  // ***************************************************
  // register map (byte addresses on the avalon slave)
  // ***************************************************
  localparam int          AW              = 5;
  localparam int          DW              = 32;
  localparam int          RW              = 16;
  localparam logic [4:0]  ADDR_BASIC_SW   = 5'h00;
  localparam logic [4:0]  ADDR_STOP_SEL   = 5'h04;
  localparam logic [4:0]  ADDR_PLUG_TQ    = 5'h08;
  localparam logic [4:0]  ADDR_ROT_DIR    = 5'h0C;
  localparam logic [4:0]  ADDR_STATUS     = 5'h10;
  localparam logic [4:0]  ADDR_POS_ERR    = 5'h14;

  // ***************************************************
  // field layout and reset values
  // ***************************************************
  localparam int          FWD_DIS_BIT     = 1;
  localparam int          REV_DIS_BIT     = 2;
  localparam int          ROT_REV_BIT     = 0;
  localparam int          SM_W            = 4;
  localparam logic [15:0] BASIC_SW_RST    = 16'h0000;
  localparam logic [15:0] STOP_SEL_RST    = 16'h0000;
  localparam logic [15:0] ROT_DIR_RST     = 16'h0000;
  localparam int          TQ_W            = 9;
  localparam logic [8:0]  PLUG_TQ_RST     = 9'h12C;
  localparam logic [8:0]  PLUG_TQ_MAX     = 9'h12C;

  // ***************************************************
  // stop methods and actions
  // ***************************************************
  localparam logic [3:0]  SM_DYN_COAST    = 4'h0;
  localparam logic [3:0]  SM_COAST_COAST  = 4'h1;
  localparam logic [3:0]  SM_PLUG_DYN     = 4'h2;
  localparam logic [3:0]  SM_PLUG_CS      = 4'h3;
  localparam logic [3:0]  SM_CLAMP_DYN    = 4'h4;
  localparam logic [3:0]  SM_CLAMP_CS     = 4'h5;

  localparam logic [1:0]  ACT_NONE        = 2'h0;
  localparam logic [1:0]  ACT_DYN         = 2'h1;
  localparam logic [1:0]  ACT_COAST       = 2'h2;
  localparam logic [1:0]  ACT_PLUG        = 2'h3;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_STOP = 3'b010,
    ST_HOLD = 3'b100
  } otls_state_t;

  localparam int          ERR_W           = 16;

endpackage

// ===== rtl/otls_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module otls_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // meta_r feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/otls_torque_cap.sv
// plug braking torque limiter, capped by the motor rating
`timescale 1ns/1ps
`default_nettype none
module otls_torque_cap
  import otls_pkg::*;
#(
  parameter logic [8:0] MOTOR_MAX = 9'h12C
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            en,
  input  wire logic [TQ_W-1:0] limit,
  output var  logic [TQ_W-1:0] torque_r
);
  // motor rating wins over a larger configured value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      torque_r <= '0;
    end else if (!en) begin
      torque_r <= '0;
    end else if (limit > MOTOR_MAX) begin
      torque_r <= MOTOR_MAX;
    end else begin
      torque_r <= limit;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/otls_top.sv
// overtravel limit stop control: limit inputs, stop sequencing, registers
// ***************************************************
// Overview of operation
// - forward limit low permits forward motion; high blocks forward motion
// - reverse limit low permits reverse motion; high blocks reverse motion
// - the direction opposite an active limit stays permitted
// - position error count kept after overtravel stop; host clear input discards it
// - basic switch bit one set ignores the forward limit input
// - basic switch bit two set ignores the reverse limit input
// - limiting works identically in speed, position and torque control
// - enable and stop-method settings take effect only after power restore
// - method 0 stops by dynamic braking then coasts
// - method 1 coasts to rest, as at servo off, then coasts
// - methods 2 and 3 plug brake then coast; servo off dynamic brake or coast
// - methods 4 and 5 plug brake then zero clamp; servo off dynamic brake or coast
// - zero clamp holds a position loop around reference zero
// - plug torque limit 0 to 300 percent, default 300, immediate effect
// - plug torque limit is the stopping torque during overtravel
// - delivered plug torque capped by the motor rating
// - rotation direction select swaps the physical direction each limit guards
// ***************************************************
`timescale 1ns/1ps
`default_nettype none
module otls_top
  import otls_pkg::*;
#(
  parameter logic [8:0] MOTOR_MAX = 9'h12C
) (
  input  wire logic                        CLK_SYS,
  input  wire logic                        SYS_RST,
  input  wire logic [otls_pkg::AW-1:0]     AVS_ADDRESS,
  input  wire logic                        AVS_READ,
  input  wire logic                        AVS_WRITE,
  input  wire logic [otls_pkg::DW-1:0]     AVS_WRITEDATA,
  input  wire logic [3:0]                  AVS_BYTEENABLE,
  output var  logic [otls_pkg::DW-1:0]     AVS_READDATA,
  output var  logic                        AVS_WAITREQUEST,
  input  wire logic                        FORWARD_LIMIT_IN,
  input  wire logic                        REVERSE_LIMIT_IN,
  input  wire logic                        ERROR_COUNTER_CLEAR_IN,
  input  wire logic                        POWER_GOOD_IN,
  input  wire logic                        SERVO_ON,
  input  wire logic                        CMD_FWD,
  input  wire logic                        CMD_REV,
  input  wire logic                        MOTOR_STOPPED,
  input  wire logic                        REF_PULSE_FWD,
  input  wire logic                        REF_PULSE_REV,
  input  wire logic                        FB_PULSE_FWD,
  input  wire logic                        FB_PULSE_REV,
  output var  logic                        CCW_PERMIT,
  output var  logic                        CW_PERMIT,
  output var  logic [1:0]                  STOP_ACTION,
  output var  logic                        COAST_MODE,
  output var  logic                        ZERO_CLAMP_MODE,
  output var  logic [otls_pkg::TQ_W-1:0]   PLUG_TORQUE_PCT,
  output var  logic [otls_pkg::ERR_W-1:0]  POSITION_ERROR,
  output var  logic [otls_pkg::ERR_W-1:0]  CLAMP_POS_ERROR
);
  import otls_pkg::*;

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [3:0]        pins_s;
  logic              fwd_lim_s;
  logic              rev_lim_s;
  logic              clr_s;
  logic              pwr_s;
  logic              pwr_d_r;
  logic              pwr_rise;

  otls_sync #(.W(4)) u_sync (
    .clk (CLK_SYS),
    .rst (SYS_RST),
    .d   ({POWER_GOOD_IN, ERROR_COUNTER_CLEAR_IN, REVERSE_LIMIT_IN, FORWARD_LIMIT_IN}),
    .q   (pins_s)
  );

  assign fwd_lim_s = pins_s[0];
  assign rev_lim_s = pins_s[1];
  assign clr_s     = pins_s[2];
  assign pwr_s     = pins_s[3];
  assign pwr_rise  = pwr_s && !pwr_d_r;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      pwr_d_r <= 1'b0;
    end else begin
      pwr_d_r <= pwr_s;
    end
  end

  // ***************************************************
  // avalon slave: one wait cycle, then the answer
  // ***************************************************
  logic [RW-1:0]     basic_switch_settings_r;
  logic [RW-1:0]     stop_method_select_r;
  logic [TQ_W-1:0]   plug_brake_torque_limit_r;
  logic [RW-1:0]     rotation_direction_select_r;
  logic              req;
  logic              wr_go;
  logic [RW-1:0]     wmask;
  logic [RW-1:0]     tq_nxt;
  logic [DW-1:0]     rdata_nxt;
  otls_state_t       st_r;

  assign req   = AVS_READ || AVS_WRITE;
  assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;
  assign wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  always_comb begin
    tq_nxt = ({7'h00, plug_brake_torque_limit_r} & ~wmask) | (AVS_WRITEDATA[RW-1:0] & wmask);
    if (tq_nxt > {7'h00, PLUG_TQ_MAX}) begin
      tq_nxt = {7'h00, PLUG_TQ_MAX};
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST);
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      basic_switch_settings_r     <= BASIC_SW_RST;
      stop_method_select_r        <= STOP_SEL_RST;
      plug_brake_torque_limit_r   <= PLUG_TQ_RST;
      rotation_direction_select_r <= ROT_DIR_RST;
    end else if (wr_go) begin
      unique case (AVS_ADDRESS)
        ADDR_BASIC_SW: basic_switch_settings_r <= (basic_switch_settings_r & ~wmask)
                                                  | (AVS_WRITEDATA[RW-1:0] & wmask);
        ADDR_STOP_SEL: stop_method_select_r <= (stop_method_select_r & ~wmask)
                                               | (AVS_WRITEDATA[RW-1:0] & wmask);
        // values above the top of range saturate; no shadow, so it acts at once
        ADDR_PLUG_TQ:  plug_brake_torque_limit_r <= tq_nxt[TQ_W-1:0];
        ADDR_ROT_DIR:  rotation_direction_select_r <= (rotation_direction_select_r & ~wmask)
                                                      | (AVS_WRITEDATA[RW-1:0] & wmask);
        default: ;
      endcase
    end
  end

  // ***************************************************
  // active configuration, taken only on power restore
  // ***************************************************
  logic              fwd_dis_act_r;
  logic              rev_dis_act_r;
  logic              rot_rev_act_r;
  logic [SM_W-1:0]   method_act_r;

  // registers survive a power cycle of the drive; only SYS_RST clears them
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fwd_dis_act_r <= BASIC_SW_RST[FWD_DIS_BIT];
      rev_dis_act_r <= BASIC_SW_RST[REV_DIS_BIT];
      rot_rev_act_r <= ROT_DIR_RST[ROT_REV_BIT];
      method_act_r  <= STOP_SEL_RST[SM_W-1:0];
    end else if (pwr_rise) begin
      fwd_dis_act_r <= basic_switch_settings_r[FWD_DIS_BIT];
      rev_dis_act_r <= basic_switch_settings_r[REV_DIS_BIT];
      rot_rev_act_r <= rotation_direction_select_r[ROT_REV_BIT];
      method_act_r  <= stop_method_select_r[SM_W-1:0];
    end
  end

  // ***************************************************
  // overtravel detection and direction permits
  // ***************************************************
  logic              fwd_ot;
  logic              rev_ot;
  logic              fwd_permit_r;
  logic              rev_permit_r;

  // no control-mode input: limiting is the same in every mode
  assign fwd_ot = fwd_lim_s && !fwd_dis_act_r;
  assign rev_ot = rev_lim_s && !rev_dis_act_r;

  // each direction judged alone, so the opposite one stays free
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fwd_permit_r <= 1'b0;
      rev_permit_r <= 1'b0;
    end else begin
      fwd_permit_r <= !fwd_ot;
      rev_permit_r <= !rev_ot;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      CCW_PERMIT <= 1'b0;
      CW_PERMIT  <= 1'b0;
    end else begin
      CCW_PERMIT <= rot_rev_act_r ? rev_permit_r : fwd_permit_r;
      CW_PERMIT  <= rot_rev_act_r ? fwd_permit_r : rev_permit_r;
    end
  end

  // ***************************************************
  // stop sequence
  // ***************************************************
  logic              ot_fwd_r;
  logic              ot_hit;
  logic              ot_clear;
  logic              clamp_sel;
  logic [1:0]        ot_act;
  logic [1:0]        soff_act;

  assign ot_hit    = (CMD_FWD && fwd_ot) || (CMD_REV && rev_ot);
  assign ot_clear  = ot_fwd_r ? (!fwd_ot || CMD_REV) : (!rev_ot || CMD_FWD);
  assign clamp_sel = (method_act_r == SM_CLAMP_DYN) || (method_act_r == SM_CLAMP_CS);

  always_comb begin
    unique case (method_act_r)
      SM_DYN_COAST:   ot_act = ACT_DYN;
      SM_COAST_COAST: ot_act = ACT_COAST;
      SM_PLUG_DYN,
      SM_PLUG_CS,
      SM_CLAMP_DYN,
      SM_CLAMP_CS:    ot_act = ACT_PLUG;
      default:        ot_act = ACT_DYN;
    endcase
    unique case (method_act_r)
      SM_COAST_COAST,
      SM_PLUG_CS,
      SM_CLAMP_CS:    soff_act = ACT_COAST;
      default:        soff_act = ACT_DYN;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r     <= ST_RUN;
      ot_fwd_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_RUN: begin
          if (ot_hit) begin
            st_r     <= ST_STOP;
            ot_fwd_r <= CMD_FWD && fwd_ot;
          end
        end
        ST_STOP: begin
          if (MOTOR_STOPPED) begin
            st_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (ot_clear) begin
            st_r <= ST_RUN;
          end
        end
        default: st_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      STOP_ACTION     <= ACT_NONE;
      COAST_MODE      <= 1'b0;
      ZERO_CLAMP_MODE <= 1'b0;
    end else begin
      STOP_ACTION     <= (st_r == ST_STOP) ? ot_act
                         : ((st_r == ST_RUN) && !SERVO_ON) ? soff_act : ACT_NONE;
      COAST_MODE      <= (st_r == ST_HOLD) && !clamp_sel;
      ZERO_CLAMP_MODE <= (st_r == ST_HOLD) && clamp_sel;
    end
  end

  // stopping torque only while plug braking is under way
  otls_torque_cap #(.MOTOR_MAX(MOTOR_MAX)) u_cap (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .en       ((st_r == ST_STOP) && (ot_act == ACT_PLUG)),
    .limit    (plug_brake_torque_limit_r),
    .torque_r (PLUG_TORQUE_PCT)
  );

  // ***************************************************
  // position error and zero clamp loop
  // ***************************************************
  logic [ERR_W-1:0]  err_nxt;
  logic [ERR_W-1:0]  clamp_nxt;

  always_comb begin
    err_nxt = POSITION_ERROR + {{(ERR_W-1){1'b0}}, REF_PULSE_FWD} - {{(ERR_W-1){1'b0}}, REF_PULSE_REV}
              - {{(ERR_W-1){1'b0}}, FB_PULSE_FWD} + {{(ERR_W-1){1'b0}}, FB_PULSE_REV};
    // reference is zero, so the error is minus the travel since entry
    clamp_nxt = CLAMP_POS_ERROR - {{(ERR_W-1){1'b0}}, FB_PULSE_FWD} + {{(ERR_W-1){1'b0}}, FB_PULSE_REV};
  end

  // the count survives the overtravel stop; only the clear pin drops it
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      POSITION_ERROR <= '0;
    end else if (clr_s) begin
      POSITION_ERROR <= '0;
    end else begin
      POSITION_ERROR <= err_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      CLAMP_POS_ERROR <= '0;
    end else if (ZERO_CLAMP_MODE) begin
      CLAMP_POS_ERROR <= clamp_nxt;
    end else begin
      CLAMP_POS_ERROR <= '0;
    end
  end

  // ***************************************************
  // read data
  // ***************************************************
  always_comb begin
    rdata_nxt = '0;
    unique case (AVS_ADDRESS)
      ADDR_BASIC_SW: rdata_nxt[RW-1:0]   = basic_switch_settings_r;
      ADDR_STOP_SEL: rdata_nxt[RW-1:0]   = stop_method_select_r;
      ADDR_PLUG_TQ:  rdata_nxt[TQ_W-1:0] = plug_brake_torque_limit_r;
      ADDR_ROT_DIR:  rdata_nxt[RW-1:0]   = rotation_direction_select_r;
      ADDR_STATUS:   rdata_nxt[15:0]     = {method_act_r, 1'b0, rot_rev_act_r, rev_dis_act_r,
                                            fwd_dis_act_r, 1'b0, st_r, rev_ot, fwd_ot,
                                            rev_lim_s, fwd_lim_s};
      ADDR_POS_ERR:  rdata_nxt[ERR_W-1:0] = POSITION_ERROR;
      default: ;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ && AVS_WAITREQUEST) begin
      AVS_READDATA <= rdata_nxt;
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  property p_fwd_block;
    fwd_ot |=> !fwd_permit_r;
  endproperty
  a_fwd_block: assert property (p_fwd_block) else $error("forward permit despite limit");

  property p_rev_block;
    rev_ot |=> !rev_permit_r;
  endproperty
  a_rev_block: assert property (p_rev_block) else $error("reverse permit despite limit");

  property p_opposite_free;
    (fwd_ot && !rev_ot) ##1 !rev_ot |-> rev_permit_r;
  endproperty
  a_opposite_free: assert property (p_opposite_free) else $error("opposite direction blocked");

  property p_clear_err;
    clr_s |=> POSITION_ERROR == '0;
  endproperty
  a_clear_err: assert property (p_clear_err) else $error("error count not cleared");

  property p_cfg_hold;
    !pwr_rise |=> $stable(method_act_r) && $stable(fwd_dis_act_r);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without power restore");

  property p_dyn_stop;
    (st_r == ST_STOP && method_act_r == SM_DYN_COAST) |=> STOP_ACTION == ACT_DYN;
  endproperty
  a_dyn_stop: assert property (p_dyn_stop) else $error("method 0 not dynamic braking");

  property p_clamp_mode;
    (st_r == ST_HOLD && clamp_sel) |=> ZERO_CLAMP_MODE && !COAST_MODE;
  endproperty
  a_clamp_mode: assert property (p_clamp_mode) else $error("zero clamp not entered");

  property p_torque_cap;
    PLUG_TORQUE_PCT <= MOTOR_MAX && plug_brake_torque_limit_r <= PLUG_TQ_MAX;
  endproperty
  a_torque_cap: assert property (p_torque_cap) else $error("plug torque above cap");

  property p_cw_map;
    ##1 1'b1 |-> CW_PERMIT == ($past(rot_rev_act_r) ? $past(fwd_permit_r) : $past(rev_permit_r));
  endproperty
  a_cw_map: assert property (p_cw_map) else $error("cw permit mapping wrong");

  property p_hold_keep;
    (st_r == ST_HOLD && !ot_clear) |=> st_r == ST_HOLD;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("post-stop mode left early");

endmodule
`default_nettype wire

// ===== dv/otls_limit_model.sv
// behavioural model of the limit switches and the host clear line
`timescale 1ns/1ps
`default_nettype none
module otls_limit_model (
  input  wire logic clk,
  input  wire logic fwd_hit,
  input  wire logic rev_hit,
  input  wire logic clr_req,
  output var  logic fwd_open,
  output var  logic rev_open,
  output var  logic clr_out
);
  // ***************************************************
  // switches and host clear
  // ***************************************************
  initial begin
    fwd_open = 1'b0;
    rev_open = 1'b0;
    clr_out  = 1'b0;
  end
  // a tripped switch opens and the pulled-up pin reads high
  always @(posedge clk) begin
    fwd_open <= fwd_hit;
    rev_open <= rev_hit;
  end
  // host discards the error count left after a stop
  always @(posedge clk) begin
    clr_out <= clr_req;
  end
endmodule
`default_nettype wire

// ===== dv/overtravel_limit_stop_control_tb.sv
// self-checking bench of the overtravel limit stop control block
`timescale 1ns/1ps
`default_nettype none
module overtravel_limit_stop_control_tb;
  import otls_pkg::*;
  // ***************************************************
  // signals
  // ***************************************************
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        wait_req, fwd_hit = 1'b0, rev_hit = 1'b0, clr_req = 1'b0;
  logic        fwd_lim, rev_lim, clr_in, pwr = 1'b1, servo = 1'b1;
  logic        cmd_f = 1'b0, stopped = 1'b0, ref_f = 1'b0, fb_f = 1'b0;
  logic        cmd_r = 1'b0, ref_r = 1'b0, fb_r = 1'b0;
  logic        ccw, cw, coast, clamp;
  logic [1:0]  act;
  logic [8:0]  tq;
  logic [15:0] perr, cerr;
  int          mismatches = 0, checks = 0, cycles = 0;

  always #50 clk = ~clk;

  otls_limit_model sw (.clk(clk), .fwd_hit(fwd_hit), .rev_hit(rev_hit), .clr_req(clr_req),
                       .fwd_open(fwd_lim), .rev_open(rev_lim), .clr_out(clr_in));

  // motor rating below the default limit so the cap is visible
  otls_top #(.MOTOR_MAX(9'h0C8)) uut (
    .CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .FORWARD_LIMIT_IN(fwd_lim), .REVERSE_LIMIT_IN(rev_lim), .ERROR_COUNTER_CLEAR_IN(clr_in),
    .POWER_GOOD_IN(pwr), .SERVO_ON(servo), .CMD_FWD(cmd_f), .CMD_REV(cmd_r), .MOTOR_STOPPED(stopped),
    .REF_PULSE_FWD(ref_f), .REF_PULSE_REV(ref_r), .FB_PULSE_FWD(fb_f), .FB_PULSE_REV(fb_r),
    .CCW_PERMIT(ccw), .CW_PERMIT(cw), .STOP_ACTION(act), .COAST_MODE(coast), .ZERO_CLAMP_MODE(clamp),
    .PLUG_TORQUE_PCT(tq), .POSITION_ERROR(perr), .CLAMP_POS_ERROR(cerr));

  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic test_done;
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      test_done;
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // request stays up until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [31:0] q);
    addr <= a;
    wdata <= {16'h0000, d};
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input string n, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(n, q, e);
  endtask

  task automatic power;
    pwr <= 1'b0;
    cyc(4);
    pwr <= 1'b1;
    // two sync edges, config load, permit, output: settled after the fifth edge
    cyc(6);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_regs;
    rchk("basic", ADDR_BASIC_SW, 32'h0);
    rchk("method", ADDR_STOP_SEL, 32'h0);
    rchk("torque", ADDR_PLUG_TQ, 32'h12C);
    wreg(ADDR_PLUG_TQ, 16'h01FF);
    rchk("torque sat", ADDR_PLUG_TQ, 32'h12C);
    rchk("unmapped", 5'h1C, 32'h0);
  endtask

  task automatic t_limits;
    fwd_hit <= 1'b1;
    cyc(6);
    chk("ccw", ccw, 1'b0);
    chk("cw", cw, 1'b1);
    fwd_hit <= 1'b0;
    rev_hit <= 1'b1;
    cyc(6);
    chk("cw", cw, 1'b0);
    chk("ccw", ccw, 1'b1);
    rev_hit <= 1'b0;
    ref_f <= 1'b1;
    cyc(3);
    ref_f <= 1'b0;
    ref_r <= 1'b1;
    fb_r <= 1'b1;
    cyc(1);
    ref_r <= 1'b0;
    cyc(1);
    fb_r <= 1'b0;
    cyc(6);
    chk("pos err", perr, 16'h0004);
    rchk("pos err reg", ADDR_POS_ERR, 32'h4);
    clr_req <= 1'b1;
    cyc(5);
    chk("pos err clr", perr, 16'h0000);
    clr_req <= 1'b0;
    cyc(2);
  endtask

  task automatic t_cfg;
    wreg(ADDR_BASIC_SW, 16'h0006);
    wreg(ADDR_ROT_DIR, 16'h0001);
    fwd_hit <= 1'b1;
    rev_hit <= 1'b1;
    cyc(6);
    chk("ccw pending", ccw, 1'b0);
    power;
    chk("ccw dis", ccw, 1'b1);
    chk("cw dis", cw, 1'b1);
    wreg(ADDR_BASIC_SW, 16'h0000);
    power;
    rev_hit <= 1'b0;
    cyc(6);
    chk("cw swapped", cw, 1'b0);
    chk("ccw swapped", ccw, 1'b1);
    fwd_hit <= 1'b0;
    wreg(ADDR_ROT_DIR, 16'h0000);
    power;
  endtask

  // each method loaded by a power restore, driven into the limit, held, released, then checked at servo off
  task automatic t_stop;
    logic [1:0] ea;
    for (int m = 0; m < 6; m++) begin
      ea = (m == 0) ? ACT_DYN : (m == 1) ? ACT_COAST : ACT_PLUG;
      wreg(ADDR_STOP_SEL, 16'(m));
      power;
      if (m == 5) wreg(ADDR_PLUG_TQ, 16'h0064);
      cmd_f <= 1'b1;
      fwd_hit <= 1'b1;
      cyc(8);
      chk("action", act, ea);
      chk("torque", tq, (ea != ACT_PLUG) ? 0 : (m == 5) ? 9'h064 : 9'h0C8);
      stopped <= 1'b1;
      cyc(3);
      fb_f <= 1'b1;
      cyc(2);
      fb_f <= 1'b0;
      cyc(6);
      chk("hold action", act, ACT_NONE);
      chk("clamp", clamp, m >= 4);
      chk("coast", coast, m < 4);
      chk("clamp err", cerr, (m >= 4) ? 16'hFFFE : 16'h0000);
      fwd_hit <= 1'b0;
      stopped <= 1'b0;
      cmd_f <= 1'b0;
      cyc(8);
      chk("released", {coast, clamp}, 2'b00);
      servo <= 1'b0;
      cyc(3);
      chk("servo off", act, m[0] ? ACT_COAST : ACT_DYN);
      servo <= 1'b1;
      cyc(3);
    end
  endtask

  // a command away from the tripped limit ends the hold at once
  task automatic t_opposite;
    cmd_f <= 1'b1;
    fwd_hit <= 1'b1;
    cyc(8);
    chk("rev free", cw, 1'b1);
    stopped <= 1'b1;
    cyc(3);
    chk("clamp held", clamp, 1'b1);
    cmd_f <= 1'b0;
    cmd_r <= 1'b1;
    cyc(3);
    chk("opposite cmd", clamp, 1'b0);
    cmd_r <= 1'b0;
    stopped <= 1'b0;
    fwd_hit <= 1'b0;
    cyc(8);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cyc(5);
    t_regs;
    t_limits;
    t_cfg;
    t_stop;
    t_opposite;
    test_done;
  end
endmodule
`default_nettype wire
